/* File: rtl/rarl_air_filter.v */
`timescale 1ns/10ps
`default_nettype none
module rarl_air_filter #(
  parameter RW = 16
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          rst,
  // Own address
  input  wire [RW-1:0] ownRadio,
  // Air receive
  input  wire          airValid,
  input  wire [RW-1:0] airDest,
  input  wire [7:0]    airData,
  input  wire          airLast,
  // Accepted
  output reg           acceptValid,
  output reg  [7:0]    acceptData,
  output reg           acceptLast
);
  reg inFrame_q;
  reg keep_q;
  wire isFirst;
  wire keepNow;
  assign isFirst = airValid && !inFrame_q;
  // Destination is judged on the first byte and held for the frame
  assign keepNow = isFirst ? (airDest == ownRadio) : keep_q;
  always @(posedge core_clk) begin
    if (rst) begin
      inFrame_q   <= 1'b0;
      keep_q      <= 1'b0;
      acceptValid <= 1'b0;
      acceptData  <= 8'h00;
      acceptLast  <= 1'b0;
    end else begin
      acceptValid <= airValid && keepNow;
      acceptData  <= airData;
      acceptLast  <= airValid && airLast && keepNow;
      if (airValid) begin
        inFrame_q <= !airLast;
        keep_q    <= keepNow;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/rarl_match.v */
`timescale 1ns/10ps
`default_nettype none
module rarl_match #(
  parameter RW = 16,
  parameter AW = 16
) (
  // Entry
  input  wire          valid,
  input  wire [1:0]    kind,
  input  wire [AW-1:0] srcLo,
  input  wire [AW-1:0] srcHi,
  input  wire [RW-1:0] radio,
  // Query
  input  wire [AW-1:0] termAddr,
  // Result
  output reg           hitSingle,
  output reg           hitSpan,
  output reg  [RW-1:0] outRadio
);
`include "rarl_regs.vh"
  wire inSpan;
  wire [AW-1:0] offs;
  assign inSpan = (termAddr >= srcLo) && (termAddr <= srcHi);
  assign offs   = termAddr - srcLo;
  always @* begin
    hitSingle = valid && (kind == `RARL_TYPE_SINGLE) && (termAddr == srcLo);
    hitSpan   = valid && inSpan &&
                ((kind == `RARL_TYPE_MAPPED) || (kind == `RARL_TYPE_RANGE));
    if (kind == `RARL_TYPE_MAPPED) begin
      // Offset is cut to radio width; wide address spaces wrap on purpose
      outRadio = radio + offs[RW-1:0];
    end else begin
      outRadio = radio;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/rarl_route_lookup.v */
`timescale 1ns/10ps
`default_nettype none
module rarl_route_lookup #(
  parameter RW      = 16,
  parameter AW      = 16,
  parameter ENTRIES = 8,
  parameter IW      = 3
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          rst,
  // Maintenance command
  input  wire          cmdValid,
  input  wire [2:0]    cmdOp,
  input  wire          cmdPort,
  input  wire [1:0]    cmdType,
  input  wire [IW-1:0] cmdRouteIndex,
  input  wire [AW-1:0] cmdSrcLo,
  input  wire [AW-1:0] cmdSrcHi,
  input  wire [RW-1:0] cmdRadio,
  input  wire          cmdModbus,
  output reg           cmdReady,
  output reg           cmdDone,
  output reg  [1:0]    cmdStatus,
  output reg  [IW-1:0] cmdIndexOut,
  // Route listing
  output reg           listValid,
  output reg  [IW-1:0] listRouteIndex,
  output reg  [1:0]    listType,
  output reg  [AW-1:0] listSrcLo,
  output reg  [AW-1:0] listSrcHi,
  output reg  [RW-1:0] listRadio,
  output reg           listLast,
  // Decoded packet from serial side
  input  wire          pktValid,
  input  wire          pktPort,
  input  wire          pktFirst,
  input  wire [AW-1:0] pktTermAddr,
  input  wire [7:0]    pktData,
  input  wire          pktEnd,
  // Over-air transmit
  output reg           txValid,
  output reg  [RW-1:0] txRadio,
  output reg  [7:0]    txData,
  output reg           txLast,
  output reg           pktDropped,
  // Own address and over-air receive
  input  wire [RW-1:0] ownRadio,
  input  wire          airValid,
  input  wire [RW-1:0] airDest,
  input  wire [7:0]    airData,
  input  wire          airLast,
  output wire          rxValid,
  output wire [7:0]    rxData,
  output wire          rxLast
);
`include "rarl_regs.vh"
  // ----------------------------------------
  // Route storage, one table per port
  // ----------------------------------------
  localparam N = 2 * ENTRIES;
  reg          ent_v_q   [0:N-1];
  reg [1:0]    ent_t_q   [0:N-1];
  reg [AW-1:0] ent_lo_q  [0:N-1];
  reg [AW-1:0] ent_hi_q  [0:N-1];
  reg [RW-1:0] ent_r_q   [0:N-1];
  reg          modbus_q  [0:1];
  reg          dflt_v_q  [0:1];
  reg [RW-1:0] dflt_r_q  [0:1];

  // ----------------------------------------
  // Lookup, combinational over selected port
  // ----------------------------------------
  wire [AW-1:0] qAddr;
  // Modbus destinations are one byte; upper bits are ignored
  assign qAddr = modbus_q[pktPort] ?
                 {{(AW-`RARL_MODBUS_BITS){1'b0}}, pktTermAddr[`RARL_MODBUS_BITS-1:0]} :
                 pktTermAddr;
  wire [ENTRIES-1:0] hSing;
  wire [ENTRIES-1:0] hSpan;
  wire [RW-1:0]      mRad [0:ENTRIES-1];
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : gMatch
      rarl_match #(.RW(RW), .AW(AW)) uMatch (
        .valid     (ent_v_q[pktPort*ENTRIES+g]),
        .kind      (ent_t_q[pktPort*ENTRIES+g]),
        .srcLo     (ent_lo_q[pktPort*ENTRIES+g]),
        .srcHi     (ent_hi_q[pktPort*ENTRIES+g]),
        .radio     (ent_r_q[pktPort*ENTRIES+g]),
        .termAddr  (qAddr),
        .hitSingle (hSing[g]),
        .hitSpan   (hSpan[g]),
        .outRadio  (mRad[g])
      );
    end
  endgenerate
  reg          found;
  reg [RW-1:0] foundRadio;
  integer k;
  always @* begin
    found      = 1'b0;
    foundRadio = `RARL_RST_RADIO;
    // Reverse scan so the lowest index is left standing
    for (k = ENTRIES - 1; k >= 0; k = k - 1) begin
      if (hSpan[k]) begin
        found      = 1'b1;
        foundRadio = mRad[k];
      end
    end
    for (k = ENTRIES - 1; k >= 0; k = k - 1) begin
      if (hSing[k]) begin
        found      = 1'b1;
        foundRadio = mRad[k];
      end
    end
    if (!found && dflt_v_q[pktPort]) begin
      found      = 1'b1;
      foundRadio = dflt_r_q[pktPort];
    end
  end

  // ----------------------------------------
  // Packet forwarding
  // ----------------------------------------
  reg          fwd_q;
  reg [RW-1:0] dest_q;
  wire         fwdNow;
  wire [RW-1:0] destNow;
  // Route is chosen on the header byte and held until packet end
  assign fwdNow  = pktFirst ? found : fwd_q;
  assign destNow = pktFirst ? foundRadio : dest_q;
  always @(posedge core_clk) begin
    if (rst) begin
      fwd_q      <= 1'b0;
      dest_q     <= `RARL_RST_RADIO;
      txValid    <= 1'b0;
      txRadio    <= `RARL_RST_RADIO;
      txData     <= 8'h00;
      txLast     <= 1'b0;
      pktDropped <= 1'b0;
    end else begin
      txValid    <= pktValid && fwdNow;
      txRadio    <= destNow;
      txData     <= pktData;
      txLast     <= pktValid && pktEnd && fwdNow;
      pktDropped <= pktValid && pktFirst && !found;
      if (pktValid) begin
        fwd_q  <= fwdNow && !pktEnd;
        dest_q <= destNow;
      end
    end
  end

  // ----------------------------------------
  // Table maintenance and listing
  // ----------------------------------------
  localparam S_IDLE = 2'h0;
  localparam S_LIST = 2'h1;
  reg [1:0]  state_q;
  reg [IW:0] scan_q;
  reg        lPort_q;
  reg        lAll_q;
  reg [1:0]  lType_q;
  // Free slot search in the command's port
  reg          freeHit;
  reg [IW-1:0] freeIdx;
  integer      f;
  always @* begin
    freeHit = 1'b0;
    freeIdx = {IW{1'b0}};
    for (f = ENTRIES - 1; f >= 0; f = f - 1) begin
      if (!ent_v_q[cmdPort*ENTRIES+f]) begin
        freeHit = 1'b1;
        freeIdx = f[IW-1:0];
      end
    end
  end
  wire [IW:0]  slot;
  wire         slotHit;
  assign slot    = {cmdPort, cmdRouteIndex};
  assign slotHit = ent_v_q[slot] && (ent_t_q[slot] == cmdType);
  wire [IW:0]  lSlot;
  wire         lHit;
  wire         scanEnd;
  assign lSlot   = {lPort_q, scan_q[IW-1:0]};
  assign lHit    = ent_v_q[lSlot] && (lAll_q || (ent_t_q[lSlot] == lType_q));
  assign scanEnd = (scan_q == ENTRIES);
  integer j;
  always @(posedge core_clk) begin
    if (rst) begin
      for (j = 0; j < N; j = j + 1) begin
        ent_v_q[j]  <= 1'b0;
        ent_t_q[j]  <= 2'h0;
        ent_lo_q[j] <= {AW{1'b0}};
        ent_hi_q[j] <= {AW{1'b0}};
        ent_r_q[j]  <= `RARL_RST_RADIO;
      end
      for (j = 0; j < 2; j = j + 1) begin
        modbus_q[j] <= 1'b0;
        dflt_v_q[j] <= 1'b0;
        dflt_r_q[j] <= `RARL_RST_RADIO;
      end
      state_q        <= S_IDLE;
      scan_q         <= {(IW+1){1'b0}};
      lPort_q        <= 1'b0;
      lAll_q         <= 1'b0;
      lType_q        <= 2'h0;
      cmdReady       <= 1'b0;
      cmdDone        <= 1'b0;
      cmdStatus      <= `RARL_ST_OK;
      cmdIndexOut    <= {IW{1'b0}};
      listValid      <= 1'b0;
      listRouteIndex <= {IW{1'b0}};
      listType       <= 2'h0;
      listSrcLo      <= {AW{1'b0}};
      listSrcHi      <= {AW{1'b0}};
      listRadio      <= `RARL_RST_RADIO;
      listLast       <= 1'b0;
    end else begin
      cmdDone   <= 1'b0;
      listValid <= 1'b0;
      listLast  <= 1'b0;
      case (state_q)
        S_IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdDone   <= 1'b1;
            cmdStatus <= `RARL_ST_OK;
            case (cmdOp)
              `RARL_CMD_ADD: begin
                if (cmdType == `RARL_TYPE_DEFAULT) begin
                  dflt_v_q[cmdPort] <= 1'b1;
                  dflt_r_q[cmdPort] <= cmdRadio;
                end else if (freeHit) begin
                  ent_v_q[{cmdPort, freeIdx}]  <= 1'b1;
                  ent_t_q[{cmdPort, freeIdx}]  <= cmdType;
                  ent_lo_q[{cmdPort, freeIdx}] <= cmdSrcLo;
                  // A single route uses its one address as both bounds
                  ent_hi_q[{cmdPort, freeIdx}] <=
                    (cmdType == `RARL_TYPE_SINGLE) ? cmdSrcLo : cmdSrcHi;
                  ent_r_q[{cmdPort, freeIdx}]  <= cmdRadio;
                  cmdIndexOut                  <= freeIdx;
                end else begin
                  cmdStatus <= `RARL_ST_FULL;
                end
              end
              `RARL_CMD_DEL: begin
                if (cmdType == `RARL_TYPE_DEFAULT) begin
                  dflt_v_q[cmdPort] <= 1'b0;
                end else if (slotHit) begin
                  ent_v_q[slot] <= 1'b0;
                end else begin
                  cmdStatus <= `RARL_ST_NOTFOUND;
                end
              end
              `RARL_CMD_DELALL, `RARL_CMD_PROTO: begin
                for (j = 0; j < ENTRIES; j = j + 1) begin
                  ent_v_q[cmdPort*ENTRIES+j] <= 1'b0;
                end
                dflt_v_q[cmdPort] <= 1'b0;
                if (cmdOp == `RARL_CMD_PROTO) begin
                  modbus_q[cmdPort] <= cmdModbus;
                end
              end
              `RARL_CMD_LISTALL, `RARL_CMD_LISTTYPE: begin
                cmdDone  <= 1'b0;
                cmdReady <= 1'b0;
                state_q  <= S_LIST;
                scan_q   <= {(IW+1){1'b0}};
                lPort_q  <= cmdPort;
                lAll_q   <= (cmdOp == `RARL_CMD_LISTALL);
                lType_q  <= cmdType;
              end
              default: begin
                cmdStatus <= `RARL_ST_NOTFOUND;
              end
            endcase
          end
        end
        S_LIST: begin
          // One table slot per cycle; default route is reported last
          if (!scanEnd) begin
            listValid      <= lHit;
            listRouteIndex <= scan_q[IW-1:0];
            listType       <= ent_t_q[lSlot];
            listSrcLo      <= ent_lo_q[lSlot];
            listSrcHi      <= ent_hi_q[lSlot];
            listRadio      <= ent_r_q[lSlot];
            scan_q         <= scan_q + 1'b1;
          end else begin
            listValid      <= dflt_v_q[lPort_q] &&
                              (lAll_q || (lType_q == `RARL_TYPE_DEFAULT));
            listRouteIndex <= {IW{1'b1}};
            listType       <= `RARL_TYPE_DEFAULT;
            listSrcLo      <= {AW{1'b0}};
            listSrcHi      <= {AW{1'b0}};
            listRadio      <= dflt_r_q[lPort_q];
            listLast       <= 1'b1;
            cmdDone        <= 1'b1;
            state_q        <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Over-air receive address filter
  // ----------------------------------------
  rarl_air_filter #(.RW(RW)) uAir (
    .core_clk    (core_clk),
    .rst         (rst),
    .ownRadio    (ownRadio),
    .airValid    (airValid),
    .airDest     (airDest),
    .airData     (airData),
    .airLast     (airLast),
    .acceptValid (rxValid),
    .acceptData  (rxData),
    .acceptLast  (rxLast)
  );
endmodule
`default_nettype wire

/* File: shared/rarl_regs.vh */
`ifndef RARL_REGS_VH
`define RARL_REGS_VH
// ----------------------------------------
// Route types
// ----------------------------------------
`define RARL_TYPE_SINGLE  2'h0
`define RARL_TYPE_MAPPED  2'h1
`define RARL_TYPE_RANGE   2'h2
`define RARL_TYPE_DEFAULT 2'h3
// ----------------------------------------
// Commands
// ----------------------------------------
`define RARL_CMD_ADD      3'h0
`define RARL_CMD_DEL      3'h1
`define RARL_CMD_DELALL   3'h2
`define RARL_CMD_LISTALL  3'h3
`define RARL_CMD_LISTTYPE 3'h4
`define RARL_CMD_PROTO    3'h5
// ----------------------------------------
// Status codes
// ----------------------------------------
`define RARL_ST_OK        2'h0
`define RARL_ST_FULL      2'h1
`define RARL_ST_NOTFOUND  2'h2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RARL_RST_RADIO    16'h0000
// ----------------------------------------
// Modbus address width in bits
// ----------------------------------------
`define RARL_MODBUS_BITS  8
`endif

/* File: sim/rarl_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rarl_master_model (
  // Clock
  input  wire logic        core_clk,
  // Decoded packet bytes
  output var  logic        pktValid,
  output var  logic        pktPort,
  output var  logic        pktFirst,
  output var  logic [15:0] pktTermAddr,
  output var  logic [7:0]  pktData,
  output var  logic        pktEnd
);
  initial begin
    pktValid = 1'b0;
    pktPort = 1'b0;
    pktFirst = 1'b0;
    pktTermAddr = 16'h0;
    pktData = 8'h0;
    pktEnd = 1'b0;
  end
  // Gap gives a slow station; idle lines flip so stale values never look valid
  task automatic send(input logic p, input logic [15:0] a, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      pktValid <= 1'b1;
      pktPort <= p;
      pktFirst <= (i == 0);
      pktTermAddr <= a;
      pktData <= 8'(i);
      pktEnd <= (i == n - 1);
      repeat (gap) begin
        @(posedge core_clk);
        pktValid <= 1'b0;
        pktData <= ~pktData;
      end
    end
    @(posedge core_clk);
    pktValid <= 1'b0;
    pktFirst <= 1'b0;
    pktEnd <= 1'b0;
    pktTermAddr <= ~a;
    pktData <= ~pktData;
  endtask
endmodule
`default_nettype wire

/* File: sim/rarl_route_lookup_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rarl_regs.vh"
module rarl_route_lookup_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        core_clk, rst, cmdValid, cmdPort, cmdModbus, cmdReady, cmdDone;
  logic [2:0]  cmdOp, cmdRouteIndex, cmdIndexOut, listRouteIndex;
  logic [1:0]  cmdType, cmdStatus, listType, lastSt;
  logic [15:0] cmdSrcLo, cmdSrcHi, cmdRadio, listSrcLo, listSrcHi, listRadio, pktTermAddr;
  logic [15:0] txRadio, ownRadio, airDest, lastRadio;
  logic [15:0] lastTx, lastRx, mapLo, mapHi, mapRadio, endRadio;
  logic [2:0]  endIdx;
  logic [1:0]  mapType;
  logic [7:0]  pktData, txData, airData, rxData;
  logic        listValid, listLast, pktValid, pktPort, pktFirst, pktEnd, txValid, txLast;
  logic        pktDropped, airValid, airLast, rxValid, rxLast;
  int          error_cnt, samples_checked, cycles, txCnt, endCnt, dropCnt, rxCnt, listCnt, rxEnd;
  rarl_route_lookup u_dut (.core_clk, .rst, .cmdValid, .cmdOp, .cmdPort, .cmdType,
    .cmdRouteIndex, .cmdSrcLo, .cmdSrcHi, .cmdRadio, .cmdModbus, .cmdReady, .cmdDone, .cmdStatus,
    .cmdIndexOut, .listValid, .listRouteIndex, .listType, .listSrcLo, .listSrcHi, .listRadio,
    .listLast, .pktValid, .pktPort, .pktFirst, .pktTermAddr, .pktData, .pktEnd, .txValid,
    .txRadio, .txData, .txLast, .pktDropped, .ownRadio, .airValid, .airDest, .airData,
    .airLast, .rxValid, .rxData, .rxLast);
  rarl_master_model u_mcs (.core_clk, .pktValid, .pktPort, .pktFirst, .pktTermAddr, .pktData,
    .pktEnd);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Counting at the falling edge keeps clear of the edge that updates outputs
  always @(negedge core_clk) begin
    if (txValid === 1'b1) begin
      txCnt++;
      lastRadio = txRadio;
      lastTx = {8'h00, txData};
    end
    if (txLast === 1'b1) endCnt++;
    if (pktDropped === 1'b1) dropCnt++;
    if (rxValid === 1'b1) begin
      rxCnt++;
      lastRx = {8'h00, rxData};
    end
    if (rxLast === 1'b1) rxEnd++;
    if (listValid === 1'b1) listCnt++;
    if (listValid === 1'b1 && listRouteIndex == 3'h1) begin
      mapType = listType;
      mapLo = listSrcLo;
      mapHi = listSrcHi;
      mapRadio = listRadio;
    end
    if (listLast === 1'b1) begin
      endRadio = listRadio;
      endIdx = listRouteIndex;
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cmd(input logic [2:0] op, input logic p, input logic [1:0] ty, input logic [2:0] ix,
           input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] rd);
    int n;
    n = 0;
    do begin @(negedge core_clk); n++; end while (cmdReady !== 1'b1 && n < 40);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdPort <= p;
    cmdType <= ty;
    cmdRouteIndex <= ix;
    cmdSrcLo <= lo;
    cmdSrcHi <= hi;
    cmdRadio <= rd;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    n = 0;
    do begin @(negedge core_clk); n++; end while (cmdDone !== 1'b1 && n < 20);
    lastSt = cmdStatus;
  endtask
  task pkt(input logic p, input logic [15:0] a, input int gap, input int expN,
           input logic [15:0] expR);
    txCnt = 0;
    endCnt = 0;
    dropCnt = 0;
    lastRadio = 16'h0;
    lastTx = 16'h0;
    u_mcs.send(p, a, 3, gap);
    repeat (3) @(negedge core_clk);
    check("txCount", 16'(txCnt), 16'(expN));
    check("txLastCount", 16'(endCnt), 16'(expN != 0));
    check("dropCount", 16'(dropCnt), 16'(expN == 0));
    check("txRadio", lastRadio, expR);
    check("txData", lastTx, (expN != 0) ? 16'h0002 : 16'h0000);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_lookup;
    logic [15:0] ad [7] = '{16'h000a, 16'h0015, 16'h0017, 16'h001c, 16'h0023, 16'h0037, 16'h0063};
    logic [15:0] rd [7] = '{16'h9000, 16'h9020, 16'h2003, 16'h2008, 16'h5000, 16'h4200, 16'h7000};
    cmd(`RARL_CMD_ADD, 1'b0, `RARL_TYPE_SINGLE, 3'h0, 16'h000a, 16'h000a, 16'h9000);
    cmd(`RARL_CMD_ADD, 1'b0, `RARL_TYPE_MAPPED, 3'h0, 16'h0014, 16'h001e, 16'h2000);
    cmd(`RARL_CMD_ADD, 1'b0, `RARL_TYPE_RANGE, 3'h0, 16'h0032, 16'h003c, 16'h4200);
    cmd(`RARL_CMD_ADD, 1'b0, `RARL_TYPE_SINGLE, 3'h0, 16'h0015, 16'h0015, 16'h9020);
    cmd(`RARL_CMD_ADD, 1'b0, `RARL_TYPE_RANGE, 3'h0, 16'h0019, 16'h0028, 16'h5000);
    check("indexOut", {13'h0, cmdIndexOut}, 16'h0004);
    cmd(`RARL_CMD_ADD, 1'b0, `RARL_TYPE_DEFAULT, 3'h0, 16'h0, 16'h0, 16'h7000);
    for (int i = 0; i < 7; i++) pkt(1'b0, ad[i], i % 2, 3, rd[i]);
    $display("test lookup done");
  endtask
  task automatic t_list;
    int exp [4] = '{2, 1, 2, 1};
    for (int t = 0; t < 4; t++) begin
      listCnt = 0;
      cmd(`RARL_CMD_LISTTYPE, 1'b0, 2'(t), 3'h0, 16'h0, 16'h0, 16'h0);
      // Let the counter take the final entry before judging
      @(posedge core_clk);
      check("listTypeCount", 16'(listCnt), 16'(exp[t]));
    end
    listCnt = 0;
    cmd(`RARL_CMD_LISTALL, 1'b0, 2'h0, 3'h0, 16'h0, 16'h0, 16'h0);
    @(posedge core_clk);
    check("listAllCount", 16'(listCnt), 16'h0006);
    check("listMapType", {14'h0, mapType}, {14'h0, `RARL_TYPE_MAPPED});
    check("listMapLo", mapLo, 16'h0014);
    check("listMapHi", mapHi, 16'h001e);
    check("listMapRadio", mapRadio, 16'h2000);
    check("listDfltRadio", endRadio, 16'h7000);
    check("listDfltIndex", {13'h0, endIdx}, 16'h0007);
    $display("test list done");
  endtask
  task t_delete;
    cmd(`RARL_CMD_DEL, 1'b0, `RARL_TYPE_RANGE, 3'h0, 16'h0, 16'h0, 16'h0);
    check("delWrongType", {14'h0, lastSt}, {14'h0, `RARL_ST_NOTFOUND});
    cmd(`RARL_CMD_DEL, 1'b0, `RARL_TYPE_SINGLE, 3'h3, 16'h0, 16'h0, 16'h0);
    check("delStatus", {14'h0, lastSt}, {14'h0, `RARL_ST_OK});
    pkt(1'b0, 16'h0015, 0, 3, 16'h2001);
    $display("test delete done");
  endtask
  task t_ports;
    cmd(`RARL_CMD_ADD, 1'b1, `RARL_TYPE_SINGLE, 3'h0, 16'h000a, 16'h000a, 16'h0100);
    cmd(`RARL_CMD_DELALL, 1'b0, 2'h0, 3'h0, 16'h0, 16'h0, 16'h0);
    pkt(1'b1, 16'h000a, 0, 3, 16'h0100);
    pkt(1'b0, 16'h000a, 0, 0, 16'h0);
    @(posedge core_clk);
    cmdModbus <= 1'b1;
    cmd(`RARL_CMD_PROTO, 1'b1, 2'h0, 3'h0, 16'h0, 16'h0, 16'h0);
    pkt(1'b1, 16'h000a, 0, 0, 16'h0);
    cmd(`RARL_CMD_ADD, 1'b1, `RARL_TYPE_SINGLE, 3'h0, 16'h000a, 16'h000a, 16'h0300);
    pkt(1'b1, 16'h550a, 1, 3, 16'h0300);
    // One entry stands in the aux table, so the eighth add finds no slot
    for (int i = 0; i < 8; i++) begin
      cmd(`RARL_CMD_ADD, 1'b1, `RARL_TYPE_RANGE, 3'h0, 16'h0100, 16'h0100, 16'h0100);
    end
    check("addFull", {14'h0, lastSt}, {14'h0, `RARL_ST_FULL});
    $display("test ports done");
  endtask
  task air(input logic [15:0] d, input int expN);
    rxCnt = 0;
    rxEnd = 0;
    lastRx = 16'h0;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      airValid <= 1'b1;
      airDest <= d;
      airData <= 8'(i);
      airLast <= (i == 1);
    end
    @(posedge core_clk);
    airValid <= 1'b0;
    airLast <= 1'b0;
    airDest <= ~d;
    repeat (2) @(negedge core_clk);
    check("rxCount", 16'(rxCnt), 16'(expN));
    check("rxLastCount", 16'(rxEnd), 16'(expN != 0));
    check("rxData", lastRx, (expN != 0) ? 16'h0001 : 16'h0000);
  endtask
  task give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {rst, cmdValid, cmdOp, cmdPort, cmdType, cmdRouteIndex, cmdModbus} = 12'h800;
    {cmdSrcLo, cmdSrcHi, cmdRadio, airDest} = 64'h0;
    {airValid, airData, airLast} = 10'h0;
    ownRadio = 16'h1234;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check("txIdle", {15'h0, txValid}, 16'h0000);
    t_lookup();
    t_list();
    t_delete();
    t_ports();
    air(16'h1234, 2);
    air(16'h4321, 0);
    $display("test air done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: sim/rarl_route_lookup_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module rarl_route_lookup_monitor #(
  parameter RW = 16
) (
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          rst,
  // Command
  input wire logic          cmdValid,
  input wire logic [2:0]    cmdOp,
  input wire logic          cmdReady,
  input wire logic          cmdDone,
  input wire logic          listValid,
  input wire logic          listLast,
  // Packet and transmit
  input wire logic          pktValid,
  input wire logic          pktFirst,
  input wire logic          pktEnd,
  input wire logic          txValid,
  input wire logic [RW-1:0] txRadio,
  input wire logic          txLast,
  input wire logic          pktDropped,
  // Air receive
  input wire logic [RW-1:0] ownRadio,
  input wire logic          airValid,
  input wire logic [RW-1:0] airDest,
  input wire logic          airLast,
  input wire logic          rxValid
);
  logic airBusy_q;
  logic airFirst;
  // First byte of a frame is the only one whose destination counts
  assign airFirst = airValid && !airBusy_q;
  always @(posedge core_clk) begin
    if (rst) begin
      airBusy_q <= 1'b0;
    end else if (airValid) begin
      airBusy_q <= !airLast;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_listTake; cmdValid && cmdReady && (cmdOp == 3'h3 || cmdOp == 3'h4); endsequence
  sequence s_listEnd;
    !cmdReady[*8] ##1 !cmdReady ##1 (cmdDone && listLast && !cmdReady) ##1 cmdReady;
  endsequence
  property p_listWalk; s_listTake |=> s_listEnd; endproperty
  a_listWalk: assert property (p_listWalk) else $error("list walk timing wrong");
  property p_listBusy; (listValid || listLast) |-> !cmdReady; endproperty
  a_listBusy: assert property (p_listBusy) else $error("list entry while idle");
  property p_shortDone;
    cmdValid && cmdReady && (cmdOp < 3'h3 || cmdOp == 3'h5) |=>
      cmdDone ##1 (!cmdDone || $past(cmdValid && cmdReady));
  endproperty
  a_shortDone: assert property (p_shortDone) else $error("command done pulse wrong");
  property p_txCause; txValid |-> $past(pktValid); endproperty
  a_txCause: assert property (p_txCause) else $error("byte sent without input");
  property p_txEnd; txLast |-> txValid && $past(pktEnd); endproperty
  a_txEnd: assert property (p_txEnd) else $error("last flag misplaced");
  property p_headerOutcome; pktValid && pktFirst |=> txValid != pktDropped; endproperty
  a_headerOutcome: assert property (p_headerOutcome) else $error("header not routed");
  property p_routeHeld; txValid && !txLast ##1 txValid |-> $stable(txRadio); endproperty
  a_routeHeld: assert property (p_routeHeld) else $error("radio changed in packet");
  property p_airAccept; airFirst && airDest == ownRadio |=> rxValid; endproperty
  a_airAccept: assert property (p_airAccept) else $error("own frame dropped");
  property p_airReject; airFirst && airDest != ownRadio |=> !rxValid; endproperty
  a_airReject: assert property (p_airReject) else $error("foreign frame taken");
endmodule
bind rarl_route_lookup rarl_route_lookup_monitor #(.RW(RW)) u_mon (.core_clk, .rst, .cmdValid,
  .cmdOp, .cmdReady, .cmdDone, .listValid, .listLast, .pktValid, .pktFirst, .pktEnd, .txValid,
  .txRadio, .txLast, .pktDropped, .ownRadio, .airValid, .airDest, .airLast, .rxValid);
`default_nettype wire
